// >>> hdl/dnr_pkg.sv
// Package: constants, map and types for the dual resistor serial slave
// How it works
// - Two resistors, 256 positions each plus high-impedance; low ends grounded.
// - Bits 0 and 1 of location 01h force resistor 0 or 1 high-impedance.
// - Setting 00h gives minimum resistance, FFh gives maximum.
// - At power-up both resistors stay high-impedance until settings are recalled.
// - Address select low: respond to A2h for writes, A3h for reads.
// - Address select high: upper seven bits of location 00h form the address.
// - Address mismatch after START: ignore the bus until the next START.
// - While protected, all reads allowed; only locations 04h and 05h writable.
// - Entry equal to setting at 06h and 07h grants full write access.
// - Entry resets to FFFFh; shipped setting FFFFh leaves device writable.
// - Repeated START acts as a START and begins a new transfer.
// - Data changes only while clock low; bits are sampled on rising clock.
// - Device drives each outgoing bit at the preceding falling clock edge.
// - Ninth bit is acknowledge: zero acknowledges, one does not.
// - Each byte is eight bits, most significant first, then acknowledge.
// - Master acknowledges bytes to continue, refuses the last; device releases data.
// - First byte after START: address in upper seven bits, direction in bit 0.
// - Second byte of a write loads the internal address pointer.
// - Writes stay in a two-byte even-aligned page and wrap within it.
// - Reads use the pointer, which advances after each byte.
// - The nonvolatile page write starts only after the closing STOP.
// - During a nonvolatile write the device refuses its slave address.
package dnr_pkg;
    // ------------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------------
    localparam logic [7:0] DNR_OFS_SLAVE_ADDR = 8'h00;
    localparam logic [7:0] DNR_OFS_HIZ = 8'h01;
    localparam logic [7:0] DNR_OFS_RES0 = 8'h02;
    localparam logic [7:0] DNR_OFS_RES1 = 8'h03;
    localparam logic [7:0] DNR_OFS_PWE_HI = 8'h04;
    localparam logic [7:0] DNR_OFS_PWE_LO = 8'h05;
    localparam logic [7:0] DNR_OFS_PWS_HI = 8'h06;
    localparam logic [7:0] DNR_OFS_PWS_LO = 8'h07;
    localparam logic [7:0] DNR_OFS_USER = 8'h10;
    localparam int DNR_NV_DEPTH = 32;
    localparam int DNR_HIZ_BIT0 = 0;
    localparam int DNR_HIZ_BIT1 = 1;
    // ------------------------------------------------------------------
    // Reset values and fixed answers
    // ------------------------------------------------------------------
    localparam logic [7:0] DNR_RST_SLAVE_ADDR = 8'ha0;
    localparam logic [7:0] DNR_RST_HIZ = 8'h00;
    localparam logic [7:0] DNR_RST_RES = 8'h7f;
    localparam logic [7:0] DNR_RST_ENTRY = 8'hff;
    localparam logic [7:0] DNR_RST_USER = 8'hff;
    localparam logic [7:0] DNR_READ_FIXED = 8'hff;
    localparam logic [6:0] DNR_FIXED_ADDR = 7'h51;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int DNR_CLK_MHZ = 100;
    localparam int DNR_NV_WRITE_MS = 10;
    localparam int DNR_NV_WRITE_CYC = DNR_NV_WRITE_MS * 1000 * DNR_CLK_MHZ;
    localparam int DNR_STARTUP_MS = 2;
    localparam int DNR_STARTUP_CYC = DNR_STARTUP_MS * 1000 * DNR_CLK_MHZ;
    localparam int DNR_CNT_W = 21;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DNR_IDLE, DNR_ADDR, DNR_ADDR_ACK, DNR_WDATA, DNR_WACK,
        DNR_RDATA, DNR_RACK
    } dnr_state_t;
endpackage : dnr_pkg

// >>> hdl/dnr_link_if.sv
// Interface: bus event strobes between the pin watcher and the slave core
`timescale 1ns/1ps
`default_nettype none
interface dnr_link_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_in;
    modport watch (output scl_rise, scl_fall, start_det, stop_det, sda_in);
    modport core (input scl_rise, scl_fall, start_det, stop_det, sda_in);
endinterface : dnr_link_if
`default_nettype wire

// >>> hdl/dnr_pin_watch.sv
// Pin watcher: synchronises the serial pins and finds edges and conditions
`timescale 1ns/1ps
`default_nettype none
module dnr_pin_watch (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    // Events to the core
    dnr_link_if.watch ev
);
    import dnr_pkg::*;
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;

    // ------------------------------------------------------------------
    // Two-stage synchronisers; only the second stage is looked at
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_pin};
            sda_sync_r <= {sda_sync_r[0], sda_pin};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    // ------------------------------------------------------------------
    // Edge and condition strobes
    // ------------------------------------------------------------------
    assign ev.sda_in = sda_sync_r[1];
    assign ev.scl_rise = scl_sync_r[1] & ~scl_d_r;
    assign ev.scl_fall = ~scl_sync_r[1] & scl_d_r;
    // Data falling while clock high is a (repeated) start
    assign ev.start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
    assign ev.stop_det = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
endmodule : dnr_pin_watch
`default_nettype wire

// >>> hdl/dnr_top.sv
// Top: serial slave, memory map, protection and resistor control
`timescale 1ns/1ps
`default_nettype none
module dnr_top #(
    parameter int NV_WRITE_CYC = dnr_pkg::DNR_NV_WRITE_CYC,
    parameter int STARTUP_CYC = dnr_pkg::DNR_STARTUP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial bus
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_out,
    output logic sda_oe,
    // Address select strap
    input wire logic addr_select,
    // Resistor controls
    output logic [7:0] resistor_zero_high_terminal,
    output logic [7:0] resistor_one_high_terminal,
    output logic hiz_enable_zero,
    output logic hiz_enable_one,
    // Status
    output logic nv_busy
);
    import dnr_pkg::*;

    dnr_link_if ev ();
    dnr_pin_watch u_watch (
        .clk(clk),
        .sys_rst(sys_rst),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .ev(ev)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] shadow_r [DNR_NV_DEPTH];
    logic [7:0] pwe_hi_r;
    logic [7:0] pwe_lo_r;
    dnr_state_t st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic rd_r;
    logic have_ptr_r;
    logic [7:0] ptr_r;
    logic [7:0] page_r;
    logic page_dirty_r;
    logic [1:0] page_mask_r;
    logic [DNR_CNT_W-1:0] cnt_r;
    logic [1:0] asel_r;
    logic booting_r;
    logic [7:0] tx_r;

    // Address select is a pin: two flops before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            asel_r <= 2'h0;
        end else begin
            asel_r <= {asel_r[0], addr_select};
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                           input logic [7:0] v);
        if (a == DNR_OFS_PWE_HI || a == DNR_OFS_PWE_LO ||
            (a >= 8'h08 && a < DNR_OFS_USER) || a >= 8'h20) begin
            rd_byte = DNR_READ_FIXED;
        end else begin
            rd_byte = v;
        end
    endfunction : rd_byte

    logic unlocked;
    logic [6:0] my_addr;
    logic [4:0] pidx;
    assign unlocked = {pwe_hi_r, pwe_lo_r} ==
        {shadow_r[DNR_OFS_PWS_HI[4:0]], shadow_r[DNR_OFS_PWS_LO[4:0]]};
    assign my_addr = asel_r[1] ? shadow_r[DNR_OFS_SLAVE_ADDR[4:0]][7:1]
                               : DNR_FIXED_ADDR;
    assign pidx = ptr_r[4:0];
    logic [7:0] rd_now;
    assign rd_now = rd_byte(ptr_r, shadow_r[pidx]);

    logic wr_ok;
    // Writable only in map and not the entry bytes, and only when unlocked
    assign wr_ok = unlocked && ptr_r < 8'h08 && ptr_r != DNR_OFS_PWE_HI &&
                   ptr_r != DNR_OFS_PWE_LO ||
                   unlocked && ptr_r >= DNR_OFS_USER && ptr_r < 8'h20;

    // ------------------------------------------------------------------
    // Serial protocol engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= DNR_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            rd_r <= 1'b0;
            have_ptr_r <= 1'b0;
            ptr_r <= 8'h00;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
            tx_r <= 8'h00;
        end else if (ev.start_det) begin
            st_r <= DNR_ADDR;
            bit_r <= 4'h0;
            sda_oe <= 1'b0;
        end else if (ev.stop_det) begin
            st_r <= DNR_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (st_r)
                DNR_IDLE: begin
                    sda_oe <= 1'b0;
                end
                DNR_ADDR: begin
                    if (ev.scl_rise) begin
                        sh_r <= {sh_r[6:0], ev.sda_in};
                        bit_r <= bit_r + 4'h1;
                    end else if (ev.scl_fall && bit_r == 4'h8) begin
                        if (sh_r[7:1] == my_addr && !nv_busy && !booting_r) begin
                            rd_r <= sh_r[0];
                            have_ptr_r <= 1'b0;
                            sda_out <= 1'b0;
                            sda_oe <= 1'b1;
                            st_r <= DNR_ADDR_ACK;
                        end else begin
                            st_r <= DNR_IDLE;
                        end
                    end
                end
                DNR_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        bit_r <= 4'h0;
                        if (rd_r) begin
                            tx_r <= rd_now;
                            sda_out <= rd_now[7];
                            sda_oe <= 1'b1;
                            st_r <= DNR_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            st_r <= DNR_WDATA;
                        end
                    end
                end
                DNR_WDATA: begin
                    if (ev.scl_rise) begin
                        sh_r <= {sh_r[6:0], ev.sda_in};
                        bit_r <= bit_r + 4'h1;
                    end else if (ev.scl_fall && bit_r == 4'h8) begin
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1;
                        st_r <= DNR_WACK;
                        if (!have_ptr_r) begin
                            ptr_r <= sh_r;
                            have_ptr_r <= 1'b1;
                        end else begin
                            ptr_r <= {ptr_r[7:1], ~ptr_r[0]};
                        end
                    end
                end
                DNR_WACK: begin
                    if (ev.scl_fall) begin
                        sda_oe <= 1'b0;
                        bit_r <= 4'h0;
                        st_r <= DNR_WDATA;
                    end
                end
                DNR_RDATA: begin
                    if (ev.scl_rise) begin
                        bit_r <= bit_r + 4'h1;
                    end else if (ev.scl_fall) begin
                        if (bit_r == 4'h8) begin
                            sda_oe <= 1'b0; // Release for master's acknowledge
                            ptr_r <= ptr_r + 8'h01;
                            st_r <= DNR_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_out <= tx_r[6];
                        end
                    end
                end
                DNR_RACK: begin
                    if (ev.scl_rise) begin
                        if (ev.sda_in) begin
                            st_r <= DNR_IDLE;
                        end else begin
                            tx_r <= rd_now;
                        end
                    end else if (ev.scl_fall) begin
                        bit_r <= 4'h0;
                        sda_out <= tx_r[7];
                        sda_oe <= 1'b1;
                        st_r <= DNR_RDATA;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Write capture into the page buffer and the entry register
    // ------------------------------------------------------------------
    logic wr_strobe;
    assign wr_strobe = st_r == DNR_WDATA && ev.scl_fall && bit_r == 4'h8 &&
                       have_ptr_r && !ev.start_det && !ev.stop_det;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwe_hi_r <= DNR_RST_ENTRY;
            pwe_lo_r <= DNR_RST_ENTRY;
        end else if (wr_strobe && ptr_r == DNR_OFS_PWE_HI) begin
            pwe_hi_r <= sh_r;
        end else if (wr_strobe && ptr_r == DNR_OFS_PWE_LO) begin
            pwe_lo_r <= sh_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            page_dirty_r <= 1'b0;
            page_mask_r <= 2'h0;
            page_r <= 8'h00;
        end else if (ev.start_det || (ev.stop_det && !nv_busy)) begin
            page_dirty_r <= 1'b0;
            page_mask_r <= 2'h0;
        end else if (wr_strobe && wr_ok) begin
            page_dirty_r <= 1'b1;
            page_r <= {ptr_r[7:1], 1'b0};
            page_mask_r[ptr_r[0]] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Shadow copy, nonvolatile store and timers
    // ------------------------------------------------------------------
    logic [7:0] page_b [2];
    always_ff @(posedge clk) begin
        if (wr_strobe && wr_ok) begin
            page_b[ptr_r[0]] <= sh_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nv_busy <= 1'b0;
            booting_r <= 1'b1;
            cnt_r <= DNR_CNT_W'(STARTUP_CYC - 1);
        end else if (booting_r) begin
            if (cnt_r == '0) begin
                booting_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end else if (nv_busy) begin
            if (cnt_r == '0) begin
                nv_busy <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end else if (ev.stop_det && page_dirty_r) begin
            nv_busy <= 1'b1;
            cnt_r <= DNR_CNT_W'(NV_WRITE_CYC - 1);
        end
    end

    // Store content persists across sys_rst; defaults load at configuration
    typedef logic [7:0] dnr_store_t [DNR_NV_DEPTH];
    function automatic dnr_store_t nv_defaults();
        dnr_store_t m;
        for (int i = 0; i < DNR_NV_DEPTH; i++) begin
            m[i] = (i >= 16) ? DNR_RST_USER : DNR_READ_FIXED;
        end
        m[0] = DNR_RST_SLAVE_ADDR;
        m[1] = DNR_RST_HIZ;
        m[2] = DNR_RST_RES;
        m[3] = DNR_RST_RES;
        return m;
    endfunction : nv_defaults
    // Declaration value only, so the store write below stays its one driver
    dnr_store_t nv_mem_r = nv_defaults();

    always_ff @(posedge clk) begin
        if (!sys_rst && ev.stop_det && page_dirty_r && !nv_busy &&
            !booting_r) begin
            for (int j = 0; j < 2; j++) begin
                if (page_mask_r[j]) begin
                    nv_mem_r[{page_r[4:1], j[0]}] <= page_b[j];
                end
            end
        end
    end

    // Live copy: recalled at start-up, follows the store after each write
    always_ff @(posedge clk) begin
        for (int k = 0; k < DNR_NV_DEPTH; k++) begin
            shadow_r[k] <= nv_mem_r[k];
        end
    end

    // ------------------------------------------------------------------
    // Resistor outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || booting_r) begin
            hiz_enable_zero <= 1'b1;
            hiz_enable_one <= 1'b1;
            resistor_zero_high_terminal <= 8'h00;
            resistor_one_high_terminal <= 8'h00;
        end else begin
            hiz_enable_zero <= shadow_r[DNR_OFS_HIZ[4:0]][DNR_HIZ_BIT0];
            hiz_enable_one <= shadow_r[DNR_OFS_HIZ[4:0]][DNR_HIZ_BIT1];
            resistor_zero_high_terminal <= shadow_r[DNR_OFS_RES0[4:0]];
            resistor_one_high_terminal <= shadow_r[DNR_OFS_RES1[4:0]];
        end
    end
endmodule : dnr_top
`default_nettype wire

// >>> test/dnr_checker.sv
// Checker: bus drive timing, write busy and start-up rules at the top ports
`timescale 1ns/1ps
`default_nettype none
module dnr_checker #(
    parameter int NV_WRITE_CYC = 50,
    parameter int STARTUP_CYC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial bus
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Status
    input wire logic hiz_enable_zero,
    input wire logic hiz_enable_one,
    input wire logic nv_busy
);
    int st_cnt;
    int bz_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Counters stand in for long repetitions the tools cannot unroll
    always_ff @(posedge clk) begin
        if (sys_rst) st_cnt <= 0;
        else if (st_cnt < STARTUP_CYC) st_cnt <= st_cnt + 1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !nv_busy) bz_cnt <= 0;
        else bz_cnt <= bz_cnt + 1;
    end
    sequence s_scl_pulse;
        ##[0:15] $rose(scl_pin) ##[1:15] $fell(scl_pin);
    endsequence
    chk_drive_scl_low: assert property (
        ($rose(sda_oe) || (sda_oe && $changed(sda_out)))
        |-> !scl_pin && !$past(scl_pin, 2))
        else $error("data drive changed while clock high");
    chk_drive_holds: assert property (
        $rose(sda_oe) |=> (sda_oe && $stable(sda_out)) throughout s_scl_pulse)
        else $error("driven bit did not stand for a clock pulse");
    chk_release_low: assert property (
        $fell(sda_oe) |-> !scl_pin && !$past(scl_pin, 2))
        else $error("data released while clock high");
    chk_busy_silent: assert property (
        nv_busy |-> !sda_oe)
        else $error("device drove data while busy");
    chk_busy_after_stop: assert property (
        $rose(nv_busy) |-> scl_pin && sda_pin && $past(scl_pin, 3))
        else $error("busy began without a stop");
    chk_busy_length: assert property (
        $fell(nv_busy) |-> bz_cnt >= NV_WRITE_CYC && bz_cnt <= NV_WRITE_CYC + 2)
        else $error("busy time wrong");
    chk_startup_hiz: assert property (
        st_cnt < STARTUP_CYC |-> hiz_enable_zero && hiz_enable_one)
        else $error("resistor not high impedance during recall");
    chk_startup_quiet: assert property (
        st_cnt < STARTUP_CYC |-> !sda_oe && !nv_busy)
        else $error("bus answered during recall");
endmodule : dnr_checker
`default_nettype wire

// >>> test/dnr_i2c_master.sv
// Partner: behavioural serial bus master with open-drain data drive
`timescale 1ns/1ps
`default_nettype none
module dnr_i2c_master (
    // Bus lines
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    // Quarter of the 125 ns bit; clock stays high between frames
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_io
    task automatic start();
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : rd_byte
endmodule : dnr_i2c_master
`default_nettype wire

// >>> test/dnr_top_tb.sv
// Testbench: slave scenarios driven through the bus master partner
`timescale 1ns/1ps
`default_nettype none
module dnr_top_tb;
    import dnr_pkg::*;
    localparam int NVC = 200;
    localparam int STC = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic addr_select = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, nv_busy, hz0, hz1;
    logic [7:0] pos0, pos1;
    logic [7:0] mem [0:31];
    logic [15:0] pe = 16'hffff;
    logic [6:0] dev = 7'h51;
    logic [31:0] seed = 32'h2c15; // Seed 11285
    int errors, tests_run, cyc;
    // Open drain with pull-up: nobody pulling low reads as one
    wire logic sda = ~sda_low & ~(sda_oe & ~sda_out);
    always #5 clk = ~clk;
    dnr_top #(.NV_WRITE_CYC(NVC), .STARTUP_CYC(STC)) i_dnr_top (
        .clk, .sys_rst, .scl_pin(scl), .sda_pin(sda), .sda_out, .sda_oe,
        .addr_select, .resistor_zero_high_terminal(pos0),
        .resistor_one_high_terminal(pos1), .hiz_enable_zero(hz0),
        .hiz_enable_one(hz1), .nv_busy);
    dnr_i2c_master i_dnr_i2c_master (.scl, .sda_low, .sda);
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a > 8'h1f || a == 8'h04 || a == 8'h05 || a[4:3] == 2'b01)
            return 8'hff;
        return mem[a[4:0]];
    endfunction : exp_rd
    function automatic logic can_wr(input logic [7:0] a);
        if (pe != {mem[6], mem[7]}) return 1'b0;
        return a < 8'h08 || (a >= 8'h10 && a < 8'h20);
    endfunction : can_wr
    function automatic logic is_me(input logic [7:0] b);
        return b[7:1] == (addr_select ? mem[0][7:1] : 7'h51);
    endfunction : is_me
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        tests_run++;
        if (got !== want) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic addr(input logic [7:0] ab, input logic e);
        logic a;
        i_dnr_i2c_master.start();
        i_dnr_i2c_master.wr_byte(ab, a);
        chk({7'h0, a}, {7'h0, e});
    endtask : addr
    task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n);
        logic a;
        logic [7:0] q;
        logic [7:0] nm [0:31];
        logic [15:0] np;
        nm = mem;
        np = pe;
        addr({dev, 1'b0}, 1'b1);
        i_dnr_i2c_master.wr_byte(p, a);
        chk({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            q = {p[7:1], p[0] ^ i[0]};
            i_dnr_i2c_master.wr_byte(d[23 - 8 * i -: 8], a);
            chk({7'h0, a}, 8'h01);
            if (q == 8'h04) np[15:8] = d[23 - 8 * i -: 8];
            else if (q == 8'h05) np[7:0] = d[23 - 8 * i -: 8];
            else if (can_wr(q)) nm[q[4:0]] = d[23 - 8 * i -: 8];
        end
        i_dnr_i2c_master.stop();
        mem = nm;
        pe = np;
    endtask : wr
    task automatic rd(input logic [7:0] p, input int n);
        logic a;
        logic [7:0] b;
        addr({dev, 1'b0}, 1'b1);
        i_dnr_i2c_master.wr_byte(p, a);
        addr({dev, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_dnr_i2c_master.rd_byte(i == n - 1, b);
            chk(b, exp_rd(p + i[7:0]));
        end
        i_dnr_i2c_master.stop();
        repeat (4) @(negedge clk);
    endtask : rd
    task automatic settle();
        repeat (12) @(negedge clk);
        for (int k = 0; k < 400 && nv_busy === 1'b1; k++) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask : settle
    task automatic outs();
        chk(pos0, mem[2]);
        chk(pos1, mem[3]);
        chk({6'h0, hz1, hz0}, {6'h0, mem[1][1:0]});
    endtask : outs
    task automatic do_rst();
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        pe = 16'hffff;
        @(negedge clk);
        chk({6'h0, hz1, hz0}, 8'h03);
        repeat (STC + 8) @(negedge clk);
    endtask : do_rst
    always @(posedge clk) begin
        cyc++;
        if (cyc > 80000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        logic [7:0] b, p;
        for (int i = 0; i < 32; i++)
            mem[i] = i == 0 ? 8'ha0 : i == 1 ? 8'h00 : i < 4 ? 8'h7f : 8'hff;
        do_rst();
        outs();
        rd(8'h00, 32);
        wr(8'h02, {rnd(), rnd(), rnd()}, 3);
        addr(8'ha2, 1'b0);
        i_dnr_i2c_master.stop();
        settle();
        outs();
        addr(8'h50, 1'b0);
        i_dnr_i2c_master.wr_byte(8'h02, b[0]);
        chk({7'h0, b[0]}, 8'h00);
        i_dnr_i2c_master.stop();
        settle();
        outs();
        for (int k = 3; k >= 0; k--) begin
            wr(8'h01, {6'h0, k[1:0], 16'h0}, 1);
            settle();
            outs();
        end
        b = rnd();
        wr(8'h00, {2'b01, b[5:1], 1'b0, 16'h0}, 1);
        settle();
        addr_select = 1'b1;
        dev = mem[0][7:1];
        rd(8'h00, 2);
        addr(8'ha2, is_me(8'ha2));
        i_dnr_i2c_master.stop();
        repeat (4) @(negedge clk);
        addr_select = 1'b0;
        dev = 7'h51;
        wr(8'h06, {rnd(), rnd(), 8'h0}, 2);
        settle();
        wr(8'h02, {rnd(), rnd(), 8'h0}, 2);
        settle();
        outs();
        rd(8'h00, 8);
        wr(8'h04, {mem[6], mem[7], 8'h0}, 2);
        settle();
        wr(8'h02, {rnd(), rnd(), 8'h0}, 2);
        settle();
        outs();
        do_rst();
        wr(8'h03, {rnd(), 16'h0}, 1);
        settle();
        outs();
        // Unlock again so the random writes below can land
        wr(8'h04, {mem[6], mem[7], 8'h0}, 2);
        settle();
        repeat (12) begin
            b = rnd();
            p = {2'b00, b[5:0]};
            wr(p, {rnd(), rnd(), rnd()}, 1 + b[7] + b[6]);
            settle();
            rd({p[7:1], 1'b0}, 2);
            outs();
        end
        end_sim();
    end
endmodule : dnr_top_tb
bind dnr_top dnr_checker #(.NV_WRITE_CYC(NV_WRITE_CYC),
    .STARTUP_CYC(STARTUP_CYC)) i_dnr_checker (.clk, .sys_rst, .scl_pin,
    .sda_pin, .sda_out, .sda_oe, .hiz_enable_zero, .hiz_enable_one,
    .nv_busy);
`default_nettype wire
